// file: rtl/gpd_top.sv
// eight gpio ports with direction control, reset pad defaults and an ahb-lite slave
`timescale 1ns/10ps
`default_nettype none

// How it works
// RQ1 - ordinary pins reset undriven, all pad controls zero
// RQ2 - debug pins reset to debug function, pulled up
// RQ3 - any reset restores both pin groups
// RQ4 - input pins: data bit captures pin level
// RQ5 - output pins: data bit driven onto pin
// RQ6 - eight ports, each with independent state
// RQ7 - port b bit 7 returns to test reset
// RQ8 - alternate select hands pin to peripheral
// RQ9 - address bits 9:2 mask data accesses
// RQ10 - writes to input bits never drive pins
module gpd_top
  import gpd_pkg::*;
(
  // clock and reset (power-on and external reset merged upstream)
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_b_i,
  // ahb-lite slave
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic      [31:0]          hrdata_o,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  // package pins
  input  wire logic [FW-1:0]        pin_in_i,
  output gpd_pad_s  [NPORT-1:0]     pad_o,
  // peripheral alternate functions
  input  wire logic [FW-1:0]        alt_out_i,
  input  wire logic [FW-1:0]        alt_oe_i,
  output logic      [FW-1:0]        alt_in_o,
  output logic                      test_rst_b_o
);

  function automatic logic [FW-1:0] port_lane(input logic [PSEL_W-1:0] p);
    port_lane = {{(FW-PW){1'b0}}, 8'hff} << {p, 3'b000};
  endfunction

  function automatic logic [PW-1:0] port_byte(input logic [FW-1:0] v,
                                              input logic [PSEL_W-1:0] p);
    port_byte = v[p*PW +: PW];
  endfunction

  // reset pad view: debug pins enabled and pulled up, everything else undriven
  function automatic gpd_pad_s [NPORT-1:0] pad_defaults(input logic [FW-1:0] dbg);
    pad_defaults = '0;
    for (int p = 0; p < NPORT; p++) begin
      pad_defaults[p].pu  = dbg[p*PW +: PW];
      pad_defaults[p].den = dbg[p*PW +: PW];
    end
  endfunction

  localparam gpd_pad_s [NPORT-1:0] PAD_RST = pad_defaults(DBG_PINS);

  logic [FW-1:0]       data_q, dir_q, afsel_q, den_q, pur_q, pdr_q;
  logic [FW-1:0]       data_d, dir_d, afsel_d, den_d, pur_d, pdr_d;
  logic [FW-1:0]       sync1_q, sync2_q;
  logic                wr_pend_q;
  logic [PSEL_W-1:0]   wr_port_q;
  logic [11:0]         wr_off_q;
  gpd_pad_s [NPORT-1:0] pad_d;

  // address phase decode
  wire                 acc      = hsel_i & htrans_i[1] & hready_i;
  wire [PSEL_W-1:0]    a_port   = haddr_i[PORT_LSB +: PSEL_W];
  wire [11:0]          a_off    = haddr_i[11:0];
  wire [PW-1:0]        a_mask   = haddr_i[MASK_LSB +: PW];
  wire                 rd_acc   = acc & ~hwrite_i;

  // data phase write lanes
  wire [FW-1:0]        lane     = wr_pend_q ? port_lane(wr_port_q) : RST_ZERO;
  wire [FW-1:0]        wrep     = {NPORT{hwdata_i[PW-1:0]}};
  wire                 wr_data  = wr_off_q < OFF_DATA_END;
  wire [FW-1:0]        dmask    = wr_data ? (lane & {NPORT{wr_off_q[MASK_LSB +: PW]}})
                                          : RST_ZERO; // RQ9
  wire [FW-1:0]        lane_dir = (wr_off_q == OFF_DIR)   ? lane : RST_ZERO;
  wire [FW-1:0]        lane_af  = (wr_off_q == OFF_AFSEL) ? lane : RST_ZERO;
  wire [FW-1:0]        lane_pu  = (wr_off_q == OFF_PUR)   ? lane : RST_ZERO;
  wire [FW-1:0]        lane_pd  = (wr_off_q == OFF_PDR)   ? lane : RST_ZERO;
  wire [FW-1:0]        lane_den = (wr_off_q == OFF_DEN)   ? lane : RST_ZERO;

  // every port sees only its own lane, so the ports never disturb each other
  assign dir_d   = (dir_q   & ~lane_dir) | (wrep & lane_dir); // RQ6
  assign afsel_d = (afsel_q & ~lane_af)  | (wrep & lane_af);
  assign pur_d   = (pur_q   & ~lane_pu)  | (wrep & lane_pu);
  assign pdr_d   = (pdr_q   & ~lane_pd)  | (wrep & lane_pd);
  assign den_d   = (den_q   & ~lane_den) | (wrep & lane_den);

  // input bits follow the pin, so a write there is simply overwritten
  wire [FW-1:0] out_val = (data_q & ~dmask) | (wrep & dmask);
  assign data_d = (out_val & dir_q) | (sync2_q & ~dir_q); // RQ4 RQ10

  // read mux, evaluated in the address phase so hrdata comes from a flop
  wire [PW-1:0] rd_data = port_byte(data_q, a_port) & a_mask; // RQ9
  logic [PW-1:0] rd_byte;
  always_comb begin
    unique case (a_off)
      OFF_DIR:   rd_byte = port_byte(dir_q, a_port);
      OFF_AFSEL: rd_byte = port_byte(afsel_q, a_port);
      OFF_PUR:   rd_byte = port_byte(pur_q, a_port);
      OFF_PDR:   rd_byte = port_byte(pdr_q, a_port);
      OFF_DEN:   rd_byte = port_byte(den_q, a_port);
      default:   rd_byte = (a_off < OFF_DATA_END) ? rd_data : 8'h00;
    endcase
  end

  // pad control: alternate function overrides direction and data
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      for (int b = 0; b < PW; b++) begin
        pad_d[p].oe[b]  = den_q[p*PW+b] &
                          (afsel_q[p*PW+b] ? alt_oe_i[p*PW+b] : dir_q[p*PW+b]); // RQ5 RQ8 RQ10
        pad_d[p].out[b] = afsel_q[p*PW+b] ? alt_out_i[p*PW+b] : data_q[p*PW+b]; // RQ5 RQ8
      end
      pad_d[p].pu  = pur_q[p*PW +: PW];
      pad_d[p].pd  = pdr_q[p*PW +: PW];
      pad_d[p].den = den_q[p*PW +: PW];
    end
  end

  // one reset puts both pin groups back to defaults
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dir_q   <= RST_ZERO;
      data_q  <= RST_ZERO;
      afsel_q <= DBG_PINS; // RQ1 RQ2 RQ3
      den_q   <= DBG_PINS; // RQ1 RQ2 RQ3
      pur_q   <= DBG_PINS; // RQ1 RQ2 RQ3
      pdr_q   <= RST_ZERO; // RQ1 RQ3
    end else begin
      dir_q   <= dir_d;
      data_q  <= data_d;
      afsel_q <= afsel_d;
      den_q   <= den_d;
      pur_q   <= pur_d;
      pdr_q   <= pdr_d;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // debug pins idle high on their pull-ups; starting the chain low
      // would pulse test reset right after every reset
      sync1_q <= DBG_PINS; // RQ7
      sync2_q <= DBG_PINS; // RQ7
    end else begin
      sync1_q <= pin_in_i;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend_q   <= 1'b0;
      wr_port_q   <= 3'h0;
      wr_off_q    <= 12'h000;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend_q   <= acc & hwrite_i;
      wr_port_q   <= a_port;
      wr_off_q    <= a_off;
      hrdata_o    <= rd_acc ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // test reset is held high unless the pin is in its debug role
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // pulls stay on while reset is held, so the debug pins never float
      pad_o        <= PAD_RST; // RQ2 RQ3
      alt_in_o     <= RST_ZERO;
      test_rst_b_o <= 1'b1;
    end else begin
      pad_o        <= pad_d;
      alt_in_o     <= sync2_q;
      test_rst_b_o <= afsel_q[TRST_BIT] ? sync2_q[TRST_BIT] : 1'b1; // RQ7
    end
  end

  // flattened pad views for checking
  logic [FW-1:0] pad_oe_v, pad_out_v;
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      pad_oe_v[p*PW +: PW]  = pad_o[p].oe;
      pad_out_v[p*PW +: PW] = pad_o[p].out;
    end
  end

  sequence s_data_wr;
    wr_pend_q && (wr_off_q < OFF_DATA_END);
  endsequence

  sequence s_data_rd;
    rd_acc && (a_off < OFF_DATA_END);
  endsequence

  a_ordinary_reset: assert property ( // RQ1
    @(posedge sys_clk_i) $rose(rst_b_i) |->
      ((afsel_q | den_q | pur_q) & ~DBG_PINS) == RST_ZERO && pdr_q == RST_ZERO)
    else $error("ordinary pins not undriven after reset");

  a_debug_reset: assert property ( // RQ2
    @(posedge sys_clk_i) $rose(rst_b_i) |->
      (afsel_q & den_q & pur_q & DBG_PINS) == DBG_PINS ##1 pad_o[1].pu[7])
    else $error("debug pins not in debug function after reset");

  a_input_capture: assert property ( // RQ4
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      rst_b_i |=> ((data_q ^ $past(sync2_q)) & ~$past(dir_q)) == RST_ZERO)
    else $error("input bit did not capture pin level");

  a_output_drive: assert property ( // RQ5
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      1'b1 |=> ((pad_out_v ^ $past(data_q)) & $past(~afsel_q)) == RST_ZERO &&
               ((~pad_oe_v) & $past(dir_q & den_q & ~afsel_q)) == RST_ZERO)
    else $error("output bit not driven onto pin");

  a_port_isolation: assert property ( // RQ6
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      wr_pend_q |=> ((dir_q ^ $past(dir_q)) & ~port_lane($past(wr_port_q))) == RST_ZERO)
    else $error("write changed another port");

  a_test_reset: assert property ( // RQ7
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      afsel_q[TRST_BIT] |=> test_rst_b_o == $past(sync2_q[TRST_BIT]))
    else $error("test reset not following pin");

  a_alt_control: assert property ( // RQ8
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      rst_b_i |=> ((pad_out_v ^ $past(alt_out_i)) & $past(afsel_q)) == RST_ZERO)
    else $error("peripheral not in control of pin");

  a_mask_write: assert property ( // RQ9
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      s_data_wr |=> ((data_q ^ $past(data_q)) & $past(dir_q & ~dmask)) == RST_ZERO)
    else $error("masked data bit changed");

  a_mask_read: assert property ( // RQ9
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      s_data_rd |=> (hrdata_o & ~{24'h00_0000, $past(a_mask)}) == 32'h0000_0000)
    else $error("masked data bit read as non-zero");

  a_input_nodrive: assert property ( // RQ10
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      1'b1 |=> (pad_oe_v & $past(~dir_q & ~afsel_q)) == RST_ZERO)
    else $error("input pin driven");

endmodule

`default_nettype wire

// file: rtl/gpd_pkg.sv
// constants and types shared by the gpio port block
package gpd_pkg;
  localparam int NPORT = 8;
  localparam int PW    = 8;
  localparam int FW    = NPORT * PW;

  // register byte offsets inside one port window
  localparam logic [11:0] OFF_DATA_END = 12'h400;
  localparam logic [11:0] OFF_DIR      = 12'h400;
  localparam logic [11:0] OFF_AFSEL    = 12'h420;
  localparam logic [11:0] OFF_PUR      = 12'h510;
  localparam logic [11:0] OFF_PDR      = 12'h514;
  localparam logic [11:0] OFF_DEN      = 12'h51c;

  // address fields
  localparam int PORT_LSB  = 12;
  localparam int MASK_LSB  = 2;
  localparam int PSEL_W    = 3;

  // debug pins: port 1 bit 7 and port 2 bits 3..0
  localparam logic [FW-1:0] DBG_PINS  = 64'h0000_0000_000f_8000;
  localparam logic [FW-1:0] RST_ZERO  = 64'h0000_0000_0000_0000;
  localparam int            TRST_BIT  = 15;

  typedef struct packed {
    logic [PW-1:0] out;
    logic [PW-1:0] oe;
    logic [PW-1:0] pu;
    logic [PW-1:0] pd;
    logic [PW-1:0] den;
  } gpd_pad_s;
endpackage

// file: test/gpd_pins.sv
// far-side model: package pins with external drivers and pad pulls
`timescale 1ns/10ps
`default_nettype none
module gpd_pins
  import gpd_pkg::*;
(
  // clock for the floating-line pattern
  input  wire logic                  sys_clk_i,
  // pads from the port and external drivers
  input  wire gpd_pad_s [NPORT-1:0]  pad_i,
  input  wire logic [FW-1:0]         ext_val_i,
  input  wire logic [FW-1:0]         ext_oe_i,
  // resolved pin levels
  output logic      [FW-1:0]         pin_o
);
  logic flip_q = 1'b0;
  always_ff @(posedge sys_clk_i) begin
    flip_q <= ~flip_q;
  end
  // a floating pin toggles so a stale level is never mistaken for a driven one
  always_comb begin
    for (int i = 0; i < FW; i++) begin
      if (pad_i[i/PW].oe[i%PW]) pin_o[i] = pad_i[i/PW].out[i%PW];
      else if (ext_oe_i[i]) pin_o[i] = ext_val_i[i];
      else if (pad_i[i/PW].pu[i%PW]) pin_o[i] = 1'b1;
      else if (pad_i[i/PW].pd[i%PW]) pin_o[i] = 1'b0;
      else pin_o[i] = flip_q ^ i[0];
    end
  end
endmodule
`default_nettype wire

// file: test/tb_gpd_top.sv
// random and corner-case bench for the gpio port block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_gpd_top import gpd_pkg::*; ;
  logic                 sys_clk_i = 0, rst_b_i = 0, hsel = 0, hwrite = 0, rdy, resp, trst_b;
  logic [1:0]           htrans = '0;
  logic [31:0]          haddr = '0, hwdata = '0, hrdata, rd;
  logic [FW-1:0]        pin, alt_in, alt_out = '0, alt_oe = '0, ext_val = '1, ext_oe = '0;
  gpd_pad_s [NPORT-1:0] pad;
  logic [7:0]           dir_m [NPORT];
  int                   failures = 0, checked = 0;
  gpd_top dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy),
    .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(resp), .pin_in_i(pin), .pad_o(pad),
    .alt_out_i(alt_out), .alt_oe_i(alt_oe), .alt_in_o(alt_in), .test_rst_b_o(trst_b));
  gpd_pins far (.sys_clk_i(sys_clk_i), .pad_i(pad), .ext_val_i(ext_val), .ext_oe_i(ext_oe),
    .pin_o(pin));
  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  task automatic tally_and_finish();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    if (rdy !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
  endtask
  // one single ahb transfer; read data taken at the edge ending the data phase
  task automatic ahb(input logic wr, input int p, input logic [11:0] off, input logic [7:0] v);
    hsel <= 1'b1;
    haddr <= {17'h0, p[2:0], off};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, v};
    wait_rdy();
    rd = hrdata;
    `CHK(resp, 1'b0)
  endtask
  task automatic do_reset();
    rst_b_i <= 1'b0;
    alt_oe <= '0;
    ext_oe <= 64'h1 << TRST_BIT;
    ext_val <= '1;
    repeat (12) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    @(posedge sys_clk_i);
    for (int p = 0; p < NPORT; p++) dir_m[p] = 8'h00;
  endtask
  task automatic chk_defaults();
    logic [7:0]  d;
    logic [11:0] offs [5];
    offs = '{OFF_AFSEL, OFF_DEN, OFF_PUR, OFF_PDR, OFF_DIR};
    for (int p = 0; p < NPORT; p++) begin
      d = DBG_PINS[p*PW +: PW];
      for (int i = 0; i < 5; i++) begin
        ahb(1'b0, p, offs[i], 8'h00);
        `CHK(rd, {24'h0, (i < 3) ? d : 8'h00})
      end
      `CHK({pad[p].pu, pad[p].den, pad[p].pd, pad[p].oe}, {d, d, 16'h0})
    end
    repeat (4) @(posedge sys_clk_i);
    `CHK(trst_b, 1'b1)
    ext_val <= '0;
    ext_oe <= 64'h1 << TRST_BIT;
    repeat (4) @(posedge sys_clk_i);
    `CHK(trst_b, 1'b0)
    ext_oe <= '0;
    ext_val <= '1;
  endtask
  initial begin
    int         p, q;
    logic [7:0] a, dir, v0, v, m, e, oe_e, ao, ax, xv;
    logic [FW-1:0] t;
    void'($urandom(93));
    do_reset();
    chk_defaults();
    for (int k = 0; k < 40; k++) begin
      p = (k < NPORT) ? k : $urandom_range(NPORT - 1);
      {a, dir, v0, v} = $urandom;
      m = 8'($urandom);
      if (k == 0) {a, m} = 16'h0000; // nothing masked in
      if (k == 1) {a, m} = 16'hff00; // all pins of port p handed to peripherals
      t = {$urandom, $urandom};
      alt_out <= t;
      ao = t[p*PW +: PW];
      t = {$urandom, $urandom};
      alt_oe <= t;
      ax = t[p*PW +: PW];
      ahb(1'b1, p, OFF_AFSEL, a);
      ahb(1'b1, p, OFF_DEN, 8'hff);
      ahb(1'b1, p, OFF_DIR, dir);
      ahb(1'b1, p, 12'h3fc, v0);
      ahb(1'b1, p, {2'b0, m, 2'b0}, v);
      dir_m[p] = dir;
      e = (v & m) | (v0 & ~m);
      oe_e = (a & ax) | (~a & dir);
      xv = $urandom;
      t = '0;
      t[p*PW +: PW] = ~oe_e;
      ext_oe <= t;
      t[p*PW +: PW] = xv;
      ext_val <= t;
      repeat (4) @(posedge sys_clk_i);
      `CHK(pad[p].oe, oe_e)
      `CHK(pad[p].out & (a | dir), (a & ao) | (~a & dir & e))
      `CHK(alt_in[p*PW +: PW] & ~oe_e, xv & ~oe_e)
      ahb(1'b0, p, 12'h3fc, 8'h00);
      `CHK(rd[7:0] & ~a, ((dir & e) | (~dir & xv)) & ~a)
      ahb(1'b0, p, {2'b0, m, 2'b0}, 8'h00);
      `CHK(rd[7:0] & ~a, ((dir & e) | (~dir & xv)) & m & ~a)
      q = $urandom_range(NPORT - 1);
      ahb(1'b0, q, OFF_DIR, 8'h00);
      `CHK(rd[7:0], dir_m[q])
      ahb(1'b0, p, 12'h600, 8'h00);
      `CHK(rd, 32'h0)
    end
    do_reset();
    chk_defaults();
    tally_and_finish();
  end
endmodule
`default_nettype wire
